// ---- src/cblc_regs.svh ----
// register offsets, field positions, reset values and timing counts
// for the clamp and black-level control block; definitions only
`ifndef CBLC_REGS_SVH
`define CBLC_REGS_SVH
`define CBLC_OFF_MISC 8'h13
`define CBLC_OFF_START_HI 8'h14
`define CBLC_OFF_START_LO 8'h15
`define CBLC_OFF_WIDTH 8'h16
`define CBLC_OFF_LOOP 8'h17
`define CBLC_OFF_STATUS 8'h20
`define CBLC_OFF_DAC_STAGE 8'h21
`define CBLC_OFF_DAC_LIVE 8'h22
`define CBLC_RST_MISC 8'h04
`define CBLC_RST_START_HI 8'h00
`define CBLC_RST_START_LO 8'h03
`define CBLC_RST_WIDTH 8'h10
`define CBLC_RST_LOOP 8'h40
`define CBLC_RST_DAC 8'h80
`define CBLC_BIT_PIN_DIS 3
`define CBLC_BIT_FUNC_LO 4
`define CBLC_BIT_XCLK_HALF 6
`define CBLC_BIT_XCLK_DIS 7
`define CBLC_BIT_LOOP_DIS 0
`define CBLC_BIT_PIXW_LO 2
`define CBLC_BIT_BW_LO 4
`define CBLC_BIT_RESTORE_EN 0
`define CBLC_MISC_WMASK 8'hFB
`define CBLC_LOOP_WMASK 8'h7D
`define CBLC_WIDTH_MIN 8'h02
`define CBLC_BW_BASE 5
`define CBLC_PIXW_BASE 4
`define CBLC_DELAY_MS 100
`define CBLC_CLK_MHZ 250
`define CBLC_DELAY_CYC (`CBLC_DELAY_MS * 1000 * `CBLC_CLK_MHZ)
`endif

// ---- src/cblc_pkg.sv ----
// types shared by the clamp and black-level control block
// assumes cblc_regs.svh is available on the include path
package cblc_pkg;
  typedef enum logic [1:0] {
    CBLC_FN_SAMPLE_CLOCK_INVERSION = 2'h0,
    CBLC_FN_CLAMP = 2'h1,
    CBLC_FN_COAST = 2'h2,
    CBLC_FN_EXTERNAL_PIXEL_CLOCK = 2'h3
  } cblc_func_type;

  typedef enum logic [1:0] {
    CBLC_IDLE,
    CBLC_WAIT_START,
    CBLC_ACTIVE
  } cblc_line_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } cblc_bus_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cblc_bus_rsp_type;

  typedef struct packed {
    logic restore_clamp;
    logic average_active;
    logic average_start;
    logic dac_load;
    logic clock_invert;
    logic ext_coast;
    logic ext_external_pixel_clock;
    logic crystal_clock_output;
  } cblc_out_type;
endpackage

// ---- src/cblc_top.sv ----
// clamp and black-level control: internal or external clamp pulse, dc
// restore, black-level averaging window, offset dac load, pin function
// select and crystal clock output. assumes hsync_in, pin inputs and
// pixel_tick are synchronous to clk; one pixel per pixel_tick.
`include "cblc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cblc_top #(
  parameter int unsigned DELAY_CYC = `CBLC_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire cblc_pkg::cblc_bus_req_type bus_req,
  output cblc_pkg::cblc_bus_rsp_type bus_rsp,
  input wire logic hsync_in,
  input wire logic pixel_tick,
  input wire logic crystal_clock_in,
  input wire logic multipurpose_input_pin,
  output cblc_pkg::cblc_out_type ctl_out,
  output logic [7:0] offset_dac,
  output logic [12:0] loop_time_constant
);

  typedef struct packed {
    logic [7:0] misc;
    logic [7:0] start_hi;
    logic [7:0] start_lo;
    logic [7:0] width;
    logic [7:0] loop;
    logic restore_en;
    logic [7:0] dac_stage;
    logic [7:0] dac_live;
    logic dac_pending;
    logic [31:0] delay_cnt;
    logic hs_d;
    logic pin_d;
    logic xclk_d;
    logic xclk_div;
    cblc_pkg::cblc_line_type line;
    logic [12:0] pix_cnt;
    logic [7:0] rest_cnt;
    logic [7:0] avg_cnt;
    logic ack;
    cblc_pkg::cblc_bus_rsp_type rsp;
    cblc_pkg::cblc_out_type out;
    logic [12:0] tconst;
  } cblc_state_type;

  cblc_state_type state_reg;
  cblc_state_type state_next;

  logic pin_level;
  logic [12:0] start_count;
  cblc_pkg::cblc_func_type func;
  logic ext_clamp_mode;
  logic clamp_pulse;
  logic [7:0] avg_len;
  logic [2:0] bw;
  logic stage_write;

  assign pin_level = multipurpose_input_pin
    & ~state_reg.misc[`CBLC_BIT_PIN_DIS];
  assign func = cblc_pkg::cblc_func_type'(
    state_reg.misc[`CBLC_BIT_FUNC_LO +: 2]);
  assign ext_clamp_mode = (func == cblc_pkg::CBLC_FN_CLAMP);
  assign start_count = {state_reg.start_hi[4:0],
    state_reg.start_lo};
  assign bw = state_reg.loop[`CBLC_BIT_BW_LO +: 3];
  assign stage_write = bus_req.write && !state_reg.ack
    && bus_req.address == `CBLC_OFF_DAC_STAGE;
  assign avg_len = 8'(8'h01 << (`CBLC_PIXW_BASE
    + state_reg.loop[`CBLC_BIT_PIXW_LO +: 2]));

  // internal clamp fires when the pixel count reaches the start point
  always_comb
  begin
    if (ext_clamp_mode)
      clamp_pulse = pin_level & ~state_reg.pin_d;
    else
      clamp_pulse = (state_reg.line == cblc_pkg::CBLC_WAIT_START)
        && pixel_tick && (state_reg.pix_cnt == start_count);
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.hs_d = hsync_in;
    state_next.pin_d = pin_level;
    state_next.ack = 1'b0;
    state_next.rsp.waitrequest = 1'b1;
    state_next.out.average_start = 1'b0;
    state_next.out.dac_load = 1'b0;

    // bus: one wait cycle, answer on the second edge
    if ((bus_req.read || bus_req.write) && !state_reg.ack)
    begin
      state_next.ack = 1'b1;
      state_next.rsp.waitrequest = 1'b0;
      state_next.rsp.readdata = 32'h0;
      unique case (bus_req.address)
        `CBLC_OFF_MISC:
          state_next.rsp.readdata[7:0] = state_reg.misc;
        `CBLC_OFF_START_HI:
          state_next.rsp.readdata[7:0] = state_reg.start_hi;
        `CBLC_OFF_START_LO:
          state_next.rsp.readdata[7:0] = state_reg.start_lo;
        `CBLC_OFF_WIDTH:
          state_next.rsp.readdata[7:0] = state_reg.width;
        `CBLC_OFF_LOOP:
          state_next.rsp.readdata[7:0] = state_reg.loop;
        `CBLC_OFF_STATUS:
          state_next.rsp.readdata[7:0] = {4'h0, state_reg.dac_pending,
            state_reg.out.average_active, state_reg.out.restore_clamp,
            state_reg.restore_en};
        `CBLC_OFF_DAC_STAGE:
          state_next.rsp.readdata[7:0] = state_reg.dac_stage;
        `CBLC_OFF_DAC_LIVE:
          state_next.rsp.readdata[7:0] = state_reg.dac_live;
        default:
          state_next.rsp.readdata = 32'h0;
      endcase
      if (bus_req.write)
      begin
        state_next.rsp.readdata = 32'h0;
        unique case (bus_req.address)
          `CBLC_OFF_MISC:
            state_next.misc = bus_req.writedata[7:0] & `CBLC_MISC_WMASK;
          `CBLC_OFF_START_HI:
            state_next.start_hi = {3'h0, bus_req.writedata[4:0]};
          `CBLC_OFF_START_LO:
            state_next.start_lo = bus_req.writedata[7:0];
          `CBLC_OFF_WIDTH:
            state_next.width = bus_req.writedata[7:0];
          `CBLC_OFF_LOOP:
            state_next.loop = bus_req.writedata[7:0] & `CBLC_LOOP_WMASK;
          `CBLC_OFF_STATUS:
            state_next.restore_en =
              bus_req.writedata[`CBLC_BIT_RESTORE_EN];
          `CBLC_OFF_DAC_STAGE:
          begin
            state_next.dac_stage = bus_req.writedata[7:0];
            state_next.dac_pending = 1'b1;
            state_next.delay_cnt = 32'h0;
          end
          default:
            state_next.rsp.readdata = 32'h0;
        endcase
      end
    end

    // line timing from hsync trailing edge
    if (state_reg.hs_d && !hsync_in)
    begin
      state_next.line = cblc_pkg::CBLC_WAIT_START;
      state_next.pix_cnt = 13'h0;
    end
    else if (pixel_tick)
    begin
      unique case (state_reg.line)
        cblc_pkg::CBLC_IDLE:
          state_next.line = cblc_pkg::CBLC_IDLE;
        cblc_pkg::CBLC_WAIT_START:
        begin
          state_next.pix_cnt = 13'(state_reg.pix_cnt + 13'h1);
          if (clamp_pulse)
            state_next.line = cblc_pkg::CBLC_ACTIVE;
        end
        cblc_pkg::CBLC_ACTIVE:
          if (!state_reg.out.restore_clamp
              && !state_reg.out.average_active)
            state_next.line = cblc_pkg::CBLC_IDLE;
      endcase
    end

    // restore pulse and averaging window, both counted in pixels
    if (clamp_pulse)
    begin
      state_next.out.dac_load = 1'b1;
      state_next.dac_live = state_reg.dac_stage;
      state_next.dac_pending = 1'b0;
      if (state_reg.restore_en && state_reg.width >= `CBLC_WIDTH_MIN)
      begin
        state_next.out.restore_clamp = 1'b1;
        state_next.rest_cnt = state_reg.width;
      end
      if (!state_reg.loop[`CBLC_BIT_LOOP_DIS])
      begin
        state_next.out.average_start = 1'b1;
        state_next.out.average_active = 1'b1;
        state_next.avg_cnt = avg_len;
      end
    end
    else if (pixel_tick)
    begin
      if (state_reg.out.restore_clamp)
      begin
        state_next.rest_cnt = 8'(state_reg.rest_cnt - 8'h01);
        if (state_reg.rest_cnt == 8'h01)
          state_next.out.restore_clamp = 1'b0;
      end
      if (state_reg.out.average_active)
      begin
        state_next.avg_cnt = 8'(state_reg.avg_cnt - 8'h01);
        if (state_reg.avg_cnt == 8'h01)
          state_next.out.average_active = 1'b0;
      end
    end
    if (state_reg.loop[`CBLC_BIT_LOOP_DIS])
      state_next.out.average_active = 1'b0;

    // pending writes reach the dac within the delay without a clamp
    if (state_reg.dac_pending && !clamp_pulse)
    begin
      state_next.delay_cnt = state_reg.delay_cnt + 32'h1;
      if (state_reg.delay_cnt >= DELAY_CYC - 1)
      begin
        state_next.dac_live = state_reg.dac_stage;
        state_next.dac_pending = 1'b0;
        state_next.out.dac_load = 1'b1;
      end
    end

    // a new staged value outlives a clamp or timeout in the same cycle
    if (stage_write)
    begin
      state_next.dac_pending = 1'b1;
      state_next.delay_cnt = 32'h0;
    end

    state_next.tconst = 13'(13'h1 << (`CBLC_BW_BASE + bw));

    state_next.out.clock_invert =
      (func == cblc_pkg::CBLC_FN_SAMPLE_CLOCK_INVERSION) & pin_level;
    state_next.out.ext_coast = (func == cblc_pkg::CBLC_FN_COAST) & pin_level;
    state_next.out.ext_external_pixel_clock =
      (func == cblc_pkg::CBLC_FN_EXTERNAL_PIXEL_CLOCK) & pin_level;

    // crystal output: divide on rising edges of the sampled crystal
    state_next.xclk_d = crystal_clock_in;
    if (crystal_clock_in && !state_reg.xclk_d)
      state_next.xclk_div = ~state_reg.xclk_div;
    if (state_reg.misc[`CBLC_BIT_XCLK_DIS])
      state_next.out.crystal_clock_output = 1'b0;
    else if (state_reg.misc[`CBLC_BIT_XCLK_HALF])
      state_next.out.crystal_clock_output = state_reg.xclk_div;
    else
      state_next.out.crystal_clock_output = crystal_clock_in;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.misc <= `CBLC_RST_MISC;
      state_reg.start_hi <= `CBLC_RST_START_HI;
      state_reg.start_lo <= `CBLC_RST_START_LO;
      state_reg.width <= `CBLC_RST_WIDTH;
      state_reg.loop <= `CBLC_RST_LOOP;
      state_reg.dac_stage <= `CBLC_RST_DAC;
      state_reg.dac_live <= `CBLC_RST_DAC;
      state_reg.restore_en <= 1'b1;
      state_reg.line <= cblc_pkg::CBLC_IDLE;
      state_reg.rsp.waitrequest <= 1'b1;
      state_reg.tconst <= 13'h0200;
    end
    else
      state_reg <= state_next;
  end

  assign bus_rsp = state_reg.rsp;
  assign ctl_out = state_reg.out;
  assign offset_dac = state_reg.dac_live;
  assign loop_time_constant = state_reg.tconst;

  property p_pin_disable;
    @(posedge clk) disable iff (!rst_b)
    state_reg.misc[`CBLC_BIT_PIN_DIS] |=> !ctl_out.clock_invert;
  endproperty
  a_pin_disable: assert property (p_pin_disable)
    else $error("disabled pin leaked through");

  property p_dac_load;
    @(posedge clk) disable iff (!rst_b)
    clamp_pulse |=> ctl_out.dac_load
      && offset_dac == $past(state_reg.dac_stage);
  endproperty
  a_dac_load: assert property (p_dac_load)
    else $error("clamp did not load dac");

  property p_no_short_restore;
    @(posedge clk) disable iff (!rst_b)
    clamp_pulse && state_reg.width < `CBLC_WIDTH_MIN
      && !ctl_out.restore_clamp |=> !ctl_out.restore_clamp;
  endproperty
  a_no_short_restore: assert property (p_no_short_restore)
    else $error("restore pulse with width below two");

  property p_restore_gated;
    @(posedge clk) disable iff (!rst_b)
    clamp_pulse && state_reg.restore_en
      && state_reg.width >= `CBLC_WIDTH_MIN |=> ctl_out.restore_clamp;
  endproperty
  a_restore_gated: assert property (p_restore_gated)
    else $error("restore pulse missing");

  property p_avg_start;
    @(posedge clk) disable iff (!rst_b)
    clamp_pulse |=> ctl_out.average_start
      == !$past(state_reg.loop[`CBLC_BIT_LOOP_DIS]);
  endproperty
  a_avg_start: assert property (p_avg_start)
    else $error("averaging start wrong");

  property p_loop_off;
    @(posedge clk) disable iff (!rst_b)
    state_reg.loop[`CBLC_BIT_LOOP_DIS] |=> !ctl_out.average_active;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loop active while disabled");

  property p_xclk_off;
    @(posedge clk) disable iff (!rst_b)
    state_reg.misc[`CBLC_BIT_XCLK_DIS] |=> !ctl_out.crystal_clock_output;
  endproperty
  a_xclk_off: assert property (p_xclk_off)
    else $error("crystal output not held low");

  property p_tconst;
    @(posedge clk) disable iff (!rst_b)
    ##1 loop_time_constant == 13'(13'h1 << (5 + $past(bw)));
  endproperty
  a_tconst: assert property (p_tconst)
    else $error("time constant mismatch");

  sequence s_ext_edge;
    ext_clamp_mode && pin_level && !state_reg.pin_d;
  endsequence

  sequence s_dac_loaded;
    ctl_out.dac_load && offset_dac == $past(state_reg.dac_stage);
  endsequence

  property p_ext_clamp;
    @(posedge clk) disable iff (!rst_b)
    s_ext_edge |=> s_dac_loaded;
  endproperty
  a_ext_clamp: assert property (p_ext_clamp)
    else $error("external clamp edge did not load dac");

  property p_ext_hold;
    @(posedge clk) disable iff (!rst_b)
    ext_clamp_mode && !clamp_pulse && !state_reg.dac_pending
      |=> $stable(offset_dac);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("dac moved without external clamp edge");

  property p_delay_load;
    @(posedge clk) disable iff (!rst_b)
    state_reg.dac_pending && !clamp_pulse
      && state_reg.delay_cnt >= DELAY_CYC - 1 |=> s_dac_loaded;
  endproperty
  a_delay_load: assert property (p_delay_load)
    else $error("pending dac value not applied after delay");

endmodule // cblc_top

`default_nettype wire

// ---- testbench/cblc_sync_gen.sv ----
// far-side timing source: hsync level and one pixel tick every other clk
// assumes clk and active-low async reset come from the bench
`timescale 1ns/100ps
`default_nettype none
module cblc_sync_gen #(
  parameter int LINE = 400,
  parameter int SYNC = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic hsync_in,
  output logic pixel_tick
);
  int cnt_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= 0;
    else
      cnt_reg <= (cnt_reg == 2 * LINE - 1) ? 0 : cnt_reg + 1;
  end
  // sync edges land on even counts, never in a tick cycle
  assign pixel_tick = cnt_reg[0];
  assign hsync_in = (cnt_reg < 2 * SYNC);
endmodule // cblc_sync_gen
`default_nettype wire

// ---- testbench/tb.sv ----
// bench for cblc_top: registers, clamp timing, pin function, crystal out
// assumes cblc_sync_gen drives hsync and pixel ticks
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int DLY = 200;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] wd;
    logic [7:0] lp;
    logic [7:0] en;
    logic [15:0] ts;
    logic [15:0] rw;
    logic [15:0] aw;
  } cblc_row_type;
  // start, width, loop cfg, restore enable; ticks to clamp, pulse widths
  cblc_row_type rows [6] = '{
    '{8'h00, 8'h05, 8'h04, 8'h00, 8'h01, 16'h006, 16'h04, 16'h10},
    '{8'hE1, 8'h05, 8'h02, 8'h04, 8'h01, 16'h106, 16'h02, 16'h20},
    '{8'h00, 8'h05, 8'h01, 8'h08, 8'h01, 16'h006, 16'h00, 16'h40},
    '{8'h00, 8'h05, 8'h00, 8'h0C, 8'h01, 16'h006, 16'h00, 16'h80},
    '{8'h00, 8'h05, 8'h08, 8'h01, 8'h01, 16'h006, 16'h08, 16'h00},
    '{8'h00, 8'h05, 8'h04, 8'h00, 8'h00, 16'h006, 16'h00, 16'h10}};
  // write flag, address, data, expected read
  logic [31:0] regs [10] = '{32'h00140000, 32'h00150003, 32'h00160010,
    32'h00170040, 32'h00310000, 32'h0117FF7D, 32'h0114FF1F, 32'h0131FF00,
    32'h00210080, 32'h00220080};
  logic [7:0] pm [6] = '{8'h00, 8'h20, 8'h30, 8'h08, 8'h38, 8'h00};
  logic [3:0] pe [6] = '{4'hC, 4'hA, 4'h9, 4'h8, 4'h8, 4'h0};
  logic [7:0] xm [3] = '{8'h00, 8'h40, 8'h80};
  logic [7:0] xp [3] = '{8'h08, 8'h10, 8'h00};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic xtal = 1'h0;
  logic pin = 1'h0;
  logic [2:0] xdiv = 3'h0;
  logic hsync_in;
  logic pixel_tick;
  logic [7:0] q;
  logic [7:0] offset_dac;
  logic [12:0] ltc;
  cblc_pkg::cblc_bus_req_type req = '0;
  cblc_pkg::cblc_bus_rsp_type rsp;
  cblc_pkg::cblc_out_type ctl;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int ts;
  int rw;
  int aw;
  int ld;
  int st;
  int p;

  cblc_top #(.DELAY_CYC(DLY)) DUT (
    .clk(clk), .rst_b(rst_b), .bus_req(req), .bus_rsp(rsp),
    .hsync_in(hsync_in), .pixel_tick(pixel_tick),
    .crystal_clock_in(xtal), .multipurpose_input_pin(pin),
    .ctl_out(ctl), .offset_dac(offset_dac), .loop_time_constant(ltc)
  );
  cblc_sync_gen src (.clk(clk), .rst_b(rst_b), .hsync_in(hsync_in),
    .pixel_tick(pixel_tick));

  always #2 clk = ~clk;

  // crystal runs at an eighth of clk; the counter cuts a hang short
  always @(posedge clk)
  begin
    xdiv <= xdiv + 3'h1;
    xtal <= xdiv[2];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end

  task stop_test();
    $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer held until waitrequest is seen low; only the
  // cycle ceiling ends a wait
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] rd);
    @(posedge clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= {24'h000000, d};
    do
    begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'h0);
    rd = rsp.readdata[7:0];
    req.read <= 1'h0;
    req.write <= 1'h0;
  endtask

  // from an hsync fall: ticks up to the clamp, ticks under each pulse
  task automatic run_line(output int a, output int b, output int c,
    output int d, output int e);
    int n;
    logic go;
    a = 0;
    b = 0;
    c = 0;
    d = 0;
    e = 0;
    n = 0;
    go = 1'h0;
    while (hsync_in !== 1'h1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    while (hsync_in !== 1'h0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (760)
    begin
      go = go | (ctl.dac_load === 1'h1);
      d += (ctl.dac_load === 1'h1);
      e += (ctl.average_start === 1'h1);
      a += (!go && pixel_tick === 1'h1);
      b += (pixel_tick === 1'h1 && ctl.restore_clamp === 1'h1);
      c += (pixel_tick === 1'h1 && ctl.average_active === 1'h1);
      @(negedge clk);
    end
  endtask

  task automatic xper(output int per);
    int n;
    int t1;
    int t2;
    logic pv;
    t1 = -1;
    t2 = -1;
    pv = 1'h1;
    for (n = 0; n < 80; n++)
    begin
      @(negedge clk);
      if (!pv && ctl.crystal_clock_output === 1'h1 && t1 >= 0 && t2 < 0)
        t2 = n;
      if (!pv && ctl.crystal_clock_output === 1'h1 && t1 < 0)
        t1 = n;
      pv = ctl.crystal_clock_output;
    end
    per = (t2 < 0) ? 0 : t2 - t1;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    check(ltc, 13'h200);
    check(offset_dac, 8'h80);
    foreach (regs[i])
    begin
      if (regs[i][24])
        bus(1'h1, regs[i][23:16], regs[i][15:8], q);
      bus(1'h0, regs[i][23:16], 8'h00, q);
      check(q, regs[i][7:0]);
    end
    $display("test registers done");
    for (int b = 0; b < 8; b++)
    begin
      bus(1'h1, 8'h17, 8'(b << 4), q);
      repeat (3) @(negedge clk);
      check(ltc, 32'(1 << (5 + b)));
    end
    $display("test time constant done");
    foreach (rows[i])
    begin
      bus(1'h1, 8'h14, rows[i].hi, q);
      bus(1'h1, 8'h15, rows[i].lo, q);
      bus(1'h1, 8'h16, rows[i].wd, q);
      bus(1'h1, 8'h17, rows[i].lp, q);
      bus(1'h1, 8'h20, rows[i].en, q);
      run_line(ts, rw, aw, ld, st);
      check(ts, rows[i].ts);
      check(rw, rows[i].rw);
      check(aw, rows[i].aw);
      check(ld, 1);
      check(st, rows[i].aw != 0);
    end
    $display("test clamp lines done");
    for (int i = 0; i < 6; i++)
    begin
      bus(1'h1, 8'h13, pm[i], q);
      pin <= pe[i][3];
      repeat (4) @(negedge clk);
      check({ctl.clock_invert, ctl.ext_coast, ctl.ext_external_pixel_clock},
        pe[i][2:0]);
    end
    $display("test pin function done");
    bus(1'h1, 8'h13, 8'h10, q);
    bus(1'h1, 8'h21, 8'h55, q);
    repeat (10) @(negedge clk);
    check(offset_dac, 8'h80);
    @(posedge clk);
    pin <= 1'h1;
    p = 0;
    do
    begin
      @(negedge clk);
      p++;
    end while (ctl.dac_load !== 1'h1 && p < 8);
    check(p < 8, 1'h1);
    @(negedge clk);
    check(offset_dac, 8'h55);
    bus(1'h1, 8'h21, 8'h33, q);
    bus(1'h0, 8'h20, 8'h00, q);
    check(q[3], 1'h1);
    repeat (DLY + 20) @(negedge clk);
    check(offset_dac, 8'h33);
    bus(1'h0, 8'h22, 8'h00, q);
    check(q, 8'h33);
    $display("test external clamp done");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'h1, 8'h13, xm[i], q);
      xper(p);
      check(p, xp[i]);
    end
    check(ctl.crystal_clock_output, 1'h0);
    $display("test crystal output done");
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(negedge clk);
    check(rsp.waitrequest, 1'h1);
    check(offset_dac, 8'h80);
    check(ltc, 13'h200);
    check(ctl, 8'h00);
    @(posedge clk);
    rst_b <= 1'h1;
    bus(1'h0, 8'h16, 8'h00, q);
    check(q, 8'h10);
    $display("test reset done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
